// >>> upfc_defines.vh
// Purpose: constants for the unknown packet forward control block
// Assumes: 32-bit AHB-Lite register slave, byte-wide registers in low bits
// Notes:   offsets are register indices; the byte address is four times the index
`ifndef UPFC_DEFINES_VH
`define UPFC_DEFINES_VH
`define UPFC_OFF_DRVMC     8'h84
`define UPFC_OFF_VLAN      8'h85
`define UPFC_OFF_SELFIP    8'h86
`define UPFC_OFF_ADDR_LO   8'h68
`define UPFC_OFF_ADDR_HI   8'h6D
`define UPFC_CTRL_RST      8'h01
`define UPFC_MAP_RST       5'h00
`define UPFC_BIT_DRV_HI    7
`define UPFC_BIT_DRV_LO    6
`define UPFC_BIT_EN        5
`define UPFC_BIT_SELF      6
`define UPFC_DRV_4MA       2'h0
`define UPFC_DRV_8MA       2'h1
`define UPFC_DRV_10MA      2'h2
`define UPFC_DRV_14MA      2'h3
`define UPFC_MA_4          4'h4
`define UPFC_MA_8          4'h8
`define UPFC_MA_10         4'hA
`define UPFC_MA_14         4'hE
`define UPFC_HTRANS_NONSEQ 2'h2
`define UPFC_IDX_MSB       9
`define UPFC_IDX_LSB       2
`define UPFC_MAP_HI        4
`define UPFC_BYTE_HI       7
`define UPFC_ADDR_BYTES    6
`endif

// >>> upfc_unknown_packet_forward_control.v
// Purpose: global forwarding controls for unmatched packets, drive select and own address
// Assumes: AHB-Lite slave, zero wait states, single word transfers, OKAY response
// Notes:   register byte address is four times its index, data in the low byte
//
// How it works
// - drive field 00,01,10,11 selects 4,8,10,14 mA on outputs
// - on the first clock after reset release drive bit1 loads inverted strap, bit0 loads strap level
// - strap low gives 10 mA; high or open gives 8 mA (01)
// - bit5 of 0x84 enables unknown non-IP multicast forwarding, resets 0
// - multicast map zero filters, set bits pick ports, resets zero
// - bit5 of 0x85 enables unknown VLAN ID forwarding, resets 0
// - VLAN map zero filters, set bits pick ports, resets zero
// - bit6 of 0x86 drops own-address packets at egress, resets 0
// - own address comes from config bytes 104 through 109
// - bit5 of 0x86 enables unknown IP multicast forwarding, resets 0
// - IP multicast map zero filters, set bits pick ports, resets zero
`timescale 1ns/100ps
`include "upfc_defines.vh"

module upfc_unknown_packet_forward_control
(
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        driveStrengthStrapPin,
   output reg  [1:0]  driveSelect,
   output reg  [3:0]  driveMilliamps,
   output reg         mcastForwardEn,
   output reg  [4:0]  mcastPortMap,
   output reg         vlanForwardEn,
   output reg  [4:0]  vlanPortMap,
   output reg         selfFilterEn,
   output reg         ipMcastForwardEn,
   output reg  [4:0]  ipMcastPortMap,
   output reg  [47:0] ownAddress
);

   // ==========================================================
   // helpers
   function [3:0] driveToMa;
      input [1:0] sel;
      begin
         case (sel)
            `UPFC_DRV_4MA:  driveToMa = `UPFC_MA_4;
            `UPFC_DRV_8MA:  driveToMa = `UPFC_MA_8;
            `UPFC_DRV_10MA: driveToMa = `UPFC_MA_10;
            default:        driveToMa = `UPFC_MA_14;
         endcase
      end
   endfunction

   // ==========================================================
   // register state
   reg  [1:0]  drive_q;
   reg         mcEn_q;
   reg  [4:0]  mcMap_q;
   reg         vlEn_q;
   reg  [4:0]  vlMap_q;
   reg         selfEn_q;
   reg         ipEn_q;
   reg  [4:0]  ipMap_q;
   reg  [7:0]  addr_q [0:5];
   reg         strapDone_q;
   reg         wrPend_q;
   reg  [7:0]  wrAddr_q;
   reg  [7:0]  rdData_d;
   integer     i;

   // ==========================================================
   // address decode
   function inAddrWindow;
      input [7:0] idx;
      begin
         inAddrWindow = (idx >= `UPFC_OFF_ADDR_LO) & (idx <= `UPFC_OFF_ADDR_HI);
      end
   endfunction

   function [2:0] addrSlot;
      input [7:0] idx;
      reg   [7:0] off;
      begin
         off      = idx - `UPFC_OFF_ADDR_LO;
         addrSlot = off[2:0];
      end
   endfunction

   // ==========================================================
   // bus decode
   wire        accept   = hsel & hready & (htrans == `UPFC_HTRANS_NONSEQ);
   wire [7:0]  aIdx     = haddr[`UPFC_IDX_MSB:`UPFC_IDX_LSB];
   wire        aIsAddr  = inAddrWindow(aIdx);
   wire [2:0]  aSlot    = addrSlot(aIdx);
   wire        wIsAddr  = inAddrWindow(wrAddr_q);
   wire [2:0]  wSlot    = addrSlot(wrAddr_q);
   wire        wrDrvmc  = wrPend_q & (wrAddr_q == `UPFC_OFF_DRVMC);
   wire        wrVlan   = wrPend_q & (wrAddr_q == `UPFC_OFF_VLAN);
   wire        wrSelfip = wrPend_q & (wrAddr_q == `UPFC_OFF_SELFIP);
   wire        wrOwn    = wrPend_q & wIsAddr;
   wire [4:0]  wMap     = hwdata[`UPFC_MAP_HI:0];
   wire [7:0]  wByte    = hwdata[`UPFC_BYTE_HI:0];

   // ==========================================================
   // read mux
   always @*
   begin
      rdData_d = 8'h00;
      case (aIdx)
         `UPFC_OFF_DRVMC:
         begin
            rdData_d = {drive_q, mcEn_q, mcMap_q};
         end
         `UPFC_OFF_VLAN:
         begin
            rdData_d = {2'h0, vlEn_q, vlMap_q};
         end
         `UPFC_OFF_SELFIP:
         begin
            rdData_d = {1'h0, selfEn_q, ipEn_q, ipMap_q};
         end
         default:
         begin
            if (aIsAddr)
            begin
               rdData_d = addr_q[aSlot];
            end
         end
      endcase
   end

   // ==========================================================
   // bus phase tracking
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
      end
      else
      begin
         wrPend_q <= accept & hwrite;
         if (accept)
         begin
            wrAddr_q <= aIdx;
         end
      end
   end

   // ==========================================================
   // bus response
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (accept & !hwrite)
         begin
            hrdata <= {24'h000000, rdData_d};
         end
      end
   end

   // ==========================================================
   // drive strength field
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         drive_q     <= `UPFC_DRV_8MA;
         strapDone_q <= 1'b0;
      end
      else
      begin
         if (!strapDone_q)
         begin
            strapDone_q <= 1'b1;
            drive_q     <= {~driveStrengthStrapPin, driveStrengthStrapPin};
         end
         if (wrDrvmc)
         begin
            drive_q <= hwdata[`UPFC_BIT_DRV_HI:`UPFC_BIT_DRV_LO];
         end
      end
   end

   // ==========================================================
   // unknown multicast
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         mcEn_q  <= 1'b0;
         mcMap_q <= `UPFC_MAP_RST;
      end
      else if (wrDrvmc)
      begin
         mcEn_q  <= hwdata[`UPFC_BIT_EN];
         mcMap_q <= wMap;
      end
   end

   // ==========================================================
   // unknown vlan id
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         vlEn_q  <= 1'b0;
         vlMap_q <= `UPFC_MAP_RST;
      end
      else if (wrVlan)
      begin
         vlEn_q  <= hwdata[`UPFC_BIT_EN];
         vlMap_q <= wMap;
      end
   end

   // ==========================================================
   // self filter and unknown ip multicast
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         selfEn_q <= 1'b0;
         ipEn_q   <= 1'b0;
         ipMap_q  <= `UPFC_MAP_RST;
      end
      else if (wrSelfip)
      begin
         selfEn_q <= hwdata[`UPFC_BIT_SELF];
         ipEn_q   <= hwdata[`UPFC_BIT_EN];
         ipMap_q  <= wMap;
      end
   end

   // ==========================================================
   // own address bytes
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         for (i = 0; i < `UPFC_ADDR_BYTES; i = i + 1)
         begin
            addr_q[i] <= 8'h00;
         end
      end
      else if (wrOwn)
      begin
         addr_q[wSlot] <= wByte;
      end
   end

   // ==========================================================
   // drive outputs
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         driveSelect    <= `UPFC_DRV_8MA;
         driveMilliamps <= `UPFC_MA_8;
      end
      else
      begin
         driveSelect    <= drive_q;
         driveMilliamps <= driveToMa(drive_q);
      end
   end

   // ==========================================================
   // multicast outputs
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         mcastForwardEn <= 1'b0;
         mcastPortMap   <= `UPFC_MAP_RST;
      end
      else
      begin
         mcastForwardEn <= mcEn_q;
         mcastPortMap   <= mcMap_q;
      end
   end

   // ==========================================================
   // vlan outputs
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         vlanForwardEn <= 1'b0;
         vlanPortMap   <= `UPFC_MAP_RST;
      end
      else
      begin
         vlanForwardEn <= vlEn_q;
         vlanPortMap   <= vlMap_q;
      end
   end

   // ==========================================================
   // self filter and ip multicast outputs
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         selfFilterEn     <= 1'b0;
         ipMcastForwardEn <= 1'b0;
         ipMcastPortMap   <= `UPFC_MAP_RST;
      end
      else
      begin
         selfFilterEn     <= selfEn_q;
         ipMcastForwardEn <= ipEn_q;
         ipMcastPortMap   <= ipMap_q;
      end
   end

   // ==========================================================
   // own address output
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ownAddress <= 48'h000000000000;
      end
      else
      begin
         ownAddress <= {addr_q[0], addr_q[1], addr_q[2],
                        addr_q[3], addr_q[4], addr_q[5]};
      end
   end

endmodule // upfc_unknown_packet_forward_control

// >>> upfc_checker_sva.sv
// Purpose: assertions on the unknown packet forward control block
// Assumes: zero wait slave, config outputs lag their registers
// Notes:   bound to the top module
`timescale 1ns/100ps
module upfc_checker
(
   input wire        sys_clk,
   input wire        rst_n,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire [31:0] hrdata,
   input wire        driveStrengthStrapPin,
   input wire [1:0]  driveSelect,
   input wire [3:0]  driveMilliamps,
   input wire        mcastForwardEn,
   input wire [4:0]  mcastPortMap,
   input wire        vlanForwardEn,
   input wire [4:0]  vlanPortMap,
   input wire        selfFilterEn,
   input wire        ipMcastForwardEn,
   input wire [4:0]  ipMcastPortMap,
   input wire [47:0] ownAddress
);
   wire       rdReq = hsel && hready && htrans == 2'h2 && !hwrite;
   wire       wrReq = hsel && htrans == 2'h2 && hwrite;
   wire [3:0] maExp = driveSelect[1] ? (driveSelect[0] ? 4'hE : 4'hA)
                                     : (driveSelect[0] ? 4'h8 : 4'h4);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ==========
   // properties
   drive_decode_a: assert property (driveMilliamps == maExp)
      else $error("drive current does not match field");
   strap_load_a: assert property ($rose(rst_n) |-> ##3 driveSelect == {~driveStrengthStrapPin, driveStrengthStrapPin})
      else $error("drive field not loaded from strap");
   reset_maps_a: assert property ($rose(rst_n) |-> mcastPortMap == 5'h00 && vlanPortMap == 5'h00 && ipMcastPortMap == 5'h00)
      else $error("port map not zero after reset");
   reset_bits_a: assert property ($rose(rst_n) |-> !mcastForwardEn && !vlanForwardEn && !selfFilterEn && !ipMcastForwardEn)
      else $error("enable not clear after reset");
   rsvd_upper_a: assert property (hrdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   rsvd_vlan_a: assert property (rdReq && haddr == 32'h00000214 |=> hrdata[7:6] == 2'h0)
      else $error("reserved vlan bits read nonzero");
   rsvd_self_a: assert property (rdReq && haddr == 32'h00000218 |=> !hrdata[7])
      else $error("reserved self bit read nonzero");
   cfg_hold_a: assert property (!wrReq [*6] |-> $stable({mcastForwardEn, mcastPortMap, vlanForwardEn, vlanPortMap,
      selfFilterEn, ipMcastForwardEn, ipMcastPortMap, ownAddress}))
      else $error("config output changed without write");
endmodule // upfc_checker
bind upfc_unknown_packet_forward_control upfc_checker i_upfc_checker (.*);

// >>> unknown_packet_forward_control_test.sv
// Purpose: directed test of the unknown packet forward control block
// Assumes: zero wait AHB-Lite slave, strap sampled after reset release
// Notes:   ports checked several cycles after each write
`timescale 1ns/100ps
module unknown_packet_forward_control_test;
   reg         sys_clk = 1'b0;
   reg         rst_n = 1'b0;
   reg         hsel = 1'b1;
   reg  [31:0] haddr = 32'h0;
   reg  [1:0]  htrans = 2'h0;
   reg         hwrite = 1'b0;
   reg  [2:0]  hsize = 3'h2;
   reg  [31:0] hwdata = 32'h0;
   reg         driveStrengthStrapPin = 1'b1;
   wire        hready, hresp, mcastForwardEn, vlanForwardEn, selfFilterEn, ipMcastForwardEn;
   wire [31:0] hrdata;
   wire [1:0]  driveSelect;
   wire [3:0]  driveMilliamps;
   wire [4:0]  mcastPortMap, vlanPortMap, ipMcastPortMap;
   wire [47:0] ownAddress;
   reg  [31:0] v;
   reg  [7:0]  d;
   integer     n_mismatch = 0, n_tests = 0, cyc = 0, i;
   upfc_unknown_packet_forward_control i_upfc_unknown_packet_forward_control (.*, .hreadyout(hready));
   always #25 sys_clk = ~sys_clk;
   task conclude;
   begin
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask
   always @(posedge sys_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 3000)
      begin
         n_mismatch = n_mismatch + 1;
         conclude;
      end
   end
   task chk(input [63:0] s, input [63:0] e);
   begin
      n_tests = n_tests + 1;
      if (s !== e)
      begin
         n_mismatch = n_mismatch + 1;
         $display("[ERR] %0t seen %0h expected %0h", $time, s, e);
      end
   end
   endtask
   // ==========
   // bus access
   task xfer(input w, input [31:0] a, input [31:0] wd);
   begin
      @(posedge sys_clk);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge sys_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hready !== 1'b1);
      v = hrdata;
   end
   endtask
   task settle;
      repeat (4) @(posedge sys_clk);
   endtask
   initial
   begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      settle;
      chk(driveSelect, 2'h1);
      chk(driveMilliamps, 4'h8);
      chk(hresp, 1'b0);
      chk(hready, 1'b1);
      xfer(0, 32'h210, 0);
      chk(v, 32'h40);
      for (i = 0; i < 4; i = i + 1)
      begin
         d = {i[1:0], i[0], {5{i[0]}}};
         xfer(1, 32'h210, {24'h0, d});
         settle;
         chk(driveSelect, i[1:0]);
         chk(driveMilliamps, i == 0 ? 4'h4 : i == 1 ? 4'h8 : i == 2 ? 4'hA : 4'hE);
         chk(mcastForwardEn, i[0]);
         chk(mcastPortMap, {5{i[0]}});
         xfer(0, 32'h210, 0);
         chk(v, {24'h0, d});
      end
      for (i = 0; i < 2; i = i + 1)
      begin
         d = i ? 8'h8A : 8'hFF;
         xfer(1, 32'h214, {24'h0, d});
         xfer(1, 32'h218, {24'h0, d});
         xfer(0, 32'h214, 0);
         chk(v, {26'h0, d[5:0]});
         xfer(0, 32'h218, 0);
         chk(v, {25'h0, d[6:0]});
         settle;
         chk(vlanForwardEn, d[5]);
         chk(vlanPortMap, d[4:0]);
         chk(selfFilterEn, d[6]);
         chk(ipMcastForwardEn, d[5]);
         chk(ipMcastPortMap, d[4:0]);
      end
      for (i = 0; i < 6; i = i + 1)
         xfer(1, 32'h1A0 + 4 * i, 8'h11 * (i + 1));
      xfer(1, 32'h240, 32'hFF);
      xfer(0, 32'h240, 0);
      chk(v, 32'h0);
      settle;
      chk(ownAddress, 48'h112233445566);
      rst_n <= 1'b0;
      driveStrengthStrapPin <= 1'b0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      settle;
      chk(driveSelect, 2'h2);
      chk(driveMilliamps, 4'hA);
      chk(vlanPortMap, 5'h00);
      conclude;
   end
endmodule // unknown_packet_forward_control_test
